// ===== rtl/ssr_status_reporting.v
// Summary of operation
// - identity query answers maker, model, serial, firmware
// - reset command restores default setup
// - save stores present setup in slot 0-9
// - recall restores setup from slot 0-9
// - event bits latch until explicitly cleared
// - event read or clear-status clears events
// - reset command leaves event bits alone
// - events latch only when enabled; masks readable
// - clear-status keeps all enable masks
// - bit 4 follows output queue message present
// - clearing events clears only its summary bit
// - bit 2 set while error queue nonempty
// - bit 3 from enabled questionable bits
// - bit 5 from enabled standard events
// - bit 6 master summary; bits 0,1,7 zero
// - clear-status clears status bits 2 and 5; bits 3 and 4 keep following their sources
// - writing zero clears status enable mask
// - operation complete after pending work finishes
// - bit 2 flags query or buffer errors
// - bits 3,4,5 flag device, execution, syntax
// - bit 7 flags reset or power-up
// - event enable command overwrites its mask
// - status query returns byte, keeps bit 6
`timescale 1ns/100ps
`include "ssr_consts.vh"

module ssr_status_reporting #(
  parameter SETUP_W = 16,
  parameter [SETUP_W-1:0] SETUP_DEFAULT = 16'h0000,
  // identity fields, values arbitrary
  parameter [7:0] ID_MAKER = 8'h11,
  parameter [7:0] ID_MODEL = 8'h22,
  parameter [7:0] ID_SERIAL = 8'h33,
  parameter [7:0] ID_FIRMWARE = 8'h44
) (
  input wire clk_sys_in,
  input wire rst_in,
  input wire cmd_valid_in,
  input wire [3:0] cmd_code_in,
  input wire [7:0] cmd_arg_in,
  output reg cmd_ready_out,
  output reg rsp_valid_out,
  output reg [7:0] rsp_data_out,
  output reg [1:0] rsp_field_out,
  output reg rsp_last_out,
  input wire ev_query_err_in,
  input wire ev_device_err_in,
  input wire ev_exec_err_in,
  input wire ev_cmd_err_in,
  input wire ops_idle_in,
  input wire err_queue_nonempty_in,
  input wire ques_summary_in,
  input wire msg_avail_in,
  input wire [SETUP_W-1:0] setup_now_in,
  output reg setup_load_out,
  output reg [SETUP_W-1:0] setup_data_out,
  output reg err_queue_clear_out,
  output reg [7:0] status_byte_out,
  output reg srq_out
);

  localparam ST_IDLE = 1'b0;
  localparam ST_IDN = 1'b1;

  reg [SETUP_W-1:0] slot_mem [0:`SSR_SLOTS-1];
  reg state_r;
  reg [1:0] idn_cnt_r;
  reg [7:0] standard_event_latch_r;
  reg [7:0] event_enable_r;
  reg [7:0] service_enable_r;
  reg [7:0] status_summary_byte_r;
  reg opc_pending_r;
  reg [7:0] event_nxt;
  reg [7:0] event_raw;
  reg [7:0] sb_nxt;
  reg [7:0] idn_byte;
  wire cmd_take;
  wire slot_ok;
  wire ev_read;
  wire ev_cls;
  wire do_idn;
  wire do_rst;
  wire do_sav;
  wire do_rcl;
  wire do_cls;
  wire do_ese;
  wire do_eseq;
  wire do_esrq;
  wire do_sre;
  wire do_sreq;
  wire do_stbq;
  wire do_opc;

  function is_cmd;
    input [3:0] code;
    input [3:0] want;
    begin
      is_cmd = (code == want);
    end
  endfunction

  assign cmd_take = cmd_valid_in && cmd_ready_out;
  assign slot_ok = (cmd_arg_in[7:4] == 4'h0) &&
    (cmd_arg_in[3:0] <= `SSR_SLOT_LAST);
  assign ev_read = cmd_take && is_cmd(cmd_code_in, `SSR_CMD_ESRQ);
  assign ev_cls = cmd_take && is_cmd(cmd_code_in, `SSR_CMD_CLS);

  // one decode per command for the dispatcher; the latch reuses save and recall, but decodes read and clear-status again
  assign do_idn = is_cmd(cmd_code_in, `SSR_CMD_IDN);
  assign do_rst = is_cmd(cmd_code_in, `SSR_CMD_RST);
  assign do_sav = is_cmd(cmd_code_in, `SSR_CMD_SAV);
  assign do_rcl = is_cmd(cmd_code_in, `SSR_CMD_RCL);
  assign do_cls = is_cmd(cmd_code_in, `SSR_CMD_CLS);
  assign do_ese = is_cmd(cmd_code_in, `SSR_CMD_ESE);
  assign do_eseq = is_cmd(cmd_code_in, `SSR_CMD_ESEQ);
  assign do_esrq = is_cmd(cmd_code_in, `SSR_CMD_ESRQ);
  assign do_sre = is_cmd(cmd_code_in, `SSR_CMD_SRE);
  assign do_sreq = is_cmd(cmd_code_in, `SSR_CMD_SREQ);
  assign do_stbq = is_cmd(cmd_code_in, `SSR_CMD_STBQ);
  assign do_opc = is_cmd(cmd_code_in, `SSR_CMD_OPC);

  // raw event sources, gated below by the enable mask
  always @* begin
    event_raw = 8'h00;
    event_raw[`SSR_EV_OPC] = opc_pending_r && ops_idle_in;
    event_raw[`SSR_EV_QUERY] = ev_query_err_in;
    event_raw[`SSR_EV_DEVICE] = ev_device_err_in;
    event_raw[`SSR_EV_EXEC] = ev_exec_err_in ||
      (cmd_take && !slot_ok && (do_sav || do_rcl));
    event_raw[`SSR_EV_CMD] = ev_cmd_err_in;
  end

  always @* begin
    event_nxt = standard_event_latch_r;
    if (ev_read || ev_cls) begin
      event_nxt = 8'h00;
    end
    // sticky, gated, set wins over clear
    event_nxt = event_nxt | (event_raw & event_enable_r);
    event_nxt = event_nxt & `SSR_EV_USED;
  end

  // condition bits are rebuilt each cycle from their sources, so
  // clearing one source drops only its own bit
  always @* begin
    sb_nxt = 8'h00;
    sb_nxt[`SSR_SB_ERRQ] = err_queue_nonempty_in && !ev_cls;
    sb_nxt[`SSR_SB_QUES] = ques_summary_in;
    sb_nxt[`SSR_SB_MAV] = msg_avail_in;
    sb_nxt[`SSR_SB_ESB] = |(event_nxt & event_enable_r);
    sb_nxt[`SSR_SB_MSS] = |(sb_nxt[5:0] & service_enable_r[5:0]);
  end

  always @* begin
    case (idn_cnt_r)
      2'h0: idn_byte = ID_MAKER;
      2'h1: idn_byte = ID_MODEL;
      2'h2: idn_byte = ID_SERIAL;
      default: idn_byte = ID_FIRMWARE;
    endcase
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      standard_event_latch_r <= `SSR_EVENT_RST;
      event_enable_r <= `SSR_ESE_RST;
      service_enable_r <= `SSR_SRE_RST;
      status_summary_byte_r <= 8'h00;
      opc_pending_r <= 1'b0;
      state_r <= ST_IDLE;
      idn_cnt_r <= 2'h0;
      cmd_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 8'h00;
      rsp_field_out <= 2'h0;
      rsp_last_out <= 1'b0;
      setup_load_out <= 1'b0;
      setup_data_out <= {SETUP_W{1'b0}};
      err_queue_clear_out <= 1'b0;
      status_byte_out <= 8'h00;
      srq_out <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      rsp_last_out <= 1'b0;
      setup_load_out <= 1'b0;
      err_queue_clear_out <= 1'b0;
      // reset command never touches the latch
      standard_event_latch_r <= event_nxt;
      // condition register refreshed; clear-status drops bits 2 and 5, and bit 6 when it came from them
      status_summary_byte_r <= sb_nxt;
      status_byte_out <= sb_nxt;
      srq_out <= sb_nxt[`SSR_SB_MSS];
      if (event_raw[`SSR_EV_OPC]) begin
        opc_pending_r <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          cmd_ready_out <= 1'b1;
          if (cmd_take) begin
            if (do_idn) begin
              state_r <= ST_IDN;
              cmd_ready_out <= 1'b0;
              idn_cnt_r <= 2'h0;
            end else if (do_rst) begin
              setup_load_out <= 1'b1;
              setup_data_out <= SETUP_DEFAULT;
              opc_pending_r <= 1'b0;
            end else if (do_sav) begin
              if (slot_ok) begin
                slot_mem[cmd_arg_in[3:0]] <= setup_now_in;
              end
            end else if (do_rcl) begin
              if (slot_ok) begin
                setup_load_out <= 1'b1;
                setup_data_out <= slot_mem[cmd_arg_in[3:0]];
              end
            end else if (do_cls) begin
              err_queue_clear_out <= 1'b1;
            end else if (do_ese) begin
              event_enable_r <= cmd_arg_in;
            end else if (do_eseq) begin
              rsp_valid_out <= 1'b1;
              rsp_last_out <= 1'b1;
              rsp_field_out <= 2'h0;
              rsp_data_out <= event_enable_r;
            end else if (do_esrq) begin
              rsp_valid_out <= 1'b1;
              rsp_last_out <= 1'b1;
              rsp_field_out <= 2'h0;
              rsp_data_out <= standard_event_latch_r;
            end else if (do_sre) begin
              service_enable_r <= cmd_arg_in;
            end else if (do_sreq) begin
              rsp_valid_out <= 1'b1;
              rsp_last_out <= 1'b1;
              rsp_field_out <= 2'h0;
              rsp_data_out <= service_enable_r;
            end else if (do_stbq) begin
              rsp_valid_out <= 1'b1;
              rsp_last_out <= 1'b1;
              rsp_field_out <= 2'h0;
              rsp_data_out <= status_summary_byte_r;
            end else if (do_opc) begin
              opc_pending_r <= 1'b1;
            end
          end
        end
        default: begin
          // identity answer: one field per cycle, ready held low
          rsp_valid_out <= 1'b1;
          rsp_data_out <= idn_byte;
          rsp_field_out <= idn_cnt_r;
          idn_cnt_r <= idn_cnt_r + 2'h1;
          if (idn_cnt_r == 2'h3) begin
            rsp_last_out <= 1'b1;
            state_r <= ST_IDLE;
            cmd_ready_out <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule // ssr_status_reporting

// ===== rtl/ssr_consts.vh
`ifndef SSR_CONSTS_VH
`define SSR_CONSTS_VH

// command codes on the command port
`define SSR_CMD_IDN 4'h0
`define SSR_CMD_RST 4'h1
`define SSR_CMD_SAV 4'h2
`define SSR_CMD_RCL 4'h3
`define SSR_CMD_CLS 4'h4
`define SSR_CMD_ESE 4'h5
`define SSR_CMD_ESEQ 4'h6
`define SSR_CMD_ESRQ 4'h7
`define SSR_CMD_SRE 4'h8
`define SSR_CMD_SREQ 4'h9
`define SSR_CMD_STBQ 4'ha
`define SSR_CMD_OPC 4'hb

// standard event latch fields
`define SSR_EV_OPC 0
`define SSR_EV_QUERY 2
`define SSR_EV_DEVICE 3
`define SSR_EV_EXEC 4
`define SSR_EV_CMD 5
`define SSR_EV_PON 7
`define SSR_EV_USED 8'hbd

// status summary byte fields
`define SSR_SB_ERRQ 2
`define SSR_SB_QUES 3
`define SSR_SB_MAV 4
`define SSR_SB_ESB 5
`define SSR_SB_MSS 6

// reset values
`define SSR_EVENT_RST 8'h80
`define SSR_ESE_RST 8'h00
`define SSR_SRE_RST 8'h00

// setup slots
`define SSR_SLOTS 10
`define SSR_SLOT_LAST 4'h9

`endif

// ===== testbench/ssr_properties.sv
`timescale 1ns/100ps
`include "ssr_consts.vh"
module ssr_properties (
  input wire clk_sys_in,
  input wire rst_in,
  input wire cmd_valid_in,
  input wire [3:0] cmd_code_in,
  input wire cmd_ready_out,
  input wire rsp_valid_out,
  input wire rsp_last_out,
  input wire err_queue_nonempty_in,
  input wire ques_summary_in,
  input wire msg_avail_in,
  input wire [7:0] status_byte_out,
  input wire srq_out
);
  wire take = cmd_valid_in && cmd_ready_out;
  wire cls = take && cmd_code_in == `SSR_CMD_CLS;
  wire qry = take && cmd_code_in inside {`SSR_CMD_ESEQ, `SSR_CMD_ESRQ,
    `SSR_CMD_SREQ, `SSR_CMD_STBQ};
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  unused_bits_a: assert property (status_byte_out[1:0] == 2'b00 &&
    !status_byte_out[7]) else $error("unused status bits set");
  srq_mss_a: assert property (srq_out == status_byte_out[6])
    else $error("service request differs from summary");
  mav_set_a: assert property (msg_avail_in && !cls |=>
    status_byte_out[4]) else $error("message bit missing");
  mav_clr_a: assert property (!msg_avail_in |=>
    !status_byte_out[4]) else $error("message bit stuck");
  errq_bit_a: assert property (err_queue_nonempty_in && !cls |=>
    status_byte_out[2]) else $error("error queue bit missing");
  ques_bit_a: assert property (ques_summary_in && !cls |=>
    status_byte_out[3]) else $error("questionable bit missing");
  idn_burst_a: assert property (take && cmd_code_in == `SSR_CMD_IDN
    |=> !cmd_ready_out ##1 (rsp_valid_out && !rsp_last_out)[*3]
    ##1 (rsp_valid_out && rsp_last_out)) else $error("bad id burst");
  query_ans_a: assert property (qry |=> rsp_valid_out)
    else $error("query not answered");
  silent_cmd_a: assert property (take && cmd_code_in == `SSR_CMD_SAV
    |=> !rsp_valid_out) else $error("save gave an answer");
endmodule // ssr_properties
bind ssr_status_reporting ssr_properties ssr_properties_inst (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
  .cmd_code_in(cmd_code_in), .cmd_ready_out(cmd_ready_out),
  .rsp_valid_out(rsp_valid_out), .rsp_last_out(rsp_last_out),
  .err_queue_nonempty_in(err_queue_nonempty_in),
  .ques_summary_in(ques_summary_in), .msg_avail_in(msg_avail_in),
  .status_byte_out(status_byte_out), .srq_out(srq_out));

// ===== testbench/ssr_host_model.sv
`timescale 1ns/100ps
module ssr_host_model (
  input wire clk_in,
  input wire rst_in,
  input wire rsp_valid_in,
  input wire [1:0] rsp_field_in,
  input wire [7:0] rsp_data_in,
  input wire err_add_in,
  input wire err_queue_clear_in,
  output reg err_queue_nonempty_out,
  output reg [31:0] id_bytes_out
);
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      err_queue_nonempty_out <= 1'b0;
      id_bytes_out <= 32'h0;
    end else begin
      // queue empties only on clear-status
      if (err_add_in)
        err_queue_nonempty_out <= 1'b1;
      else if (err_queue_clear_in)
        err_queue_nonempty_out <= 1'b0;
      if (rsp_valid_in)
        id_bytes_out[24 - 8 * rsp_field_in +: 8] <= rsp_data_in;
    end
  end
endmodule // ssr_host_model

// ===== testbench/ssr_status_reporting_bench.sv
`timescale 1ns/100ps
`include "ssr_consts.vh"
module ssr_status_reporting_bench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg vld = 1'b0;
  reg [3:0] code = 4'h0;
  reg [7:0] arg = 8'h00;
  reg [4:0] ev = 5'h00;
  reg idle = 1'b1;
  reg ques = 1'b0;
  reg mav = 1'b0;
  reg [15:0] setup = 16'h0000;
  wire rdy, rv, rl, load, eqc, srq, eqn;
  wire [7:0] rd, sb;
  wire [1:0] rf;
  wire [15:0] sd;
  wire [31:0] ids;
  integer failures = 0;
  integer check_count = 0;
  integer cycles = 0;
  ssr_status_reporting ssr_status_reporting_inst (.clk_sys_in(clk),
    .rst_in(rst), .cmd_valid_in(vld), .cmd_code_in(code), .cmd_arg_in(arg),
    .cmd_ready_out(rdy), .rsp_valid_out(rv), .rsp_data_out(rd),
    .rsp_field_out(rf), .rsp_last_out(rl), .ev_query_err_in(ev[0]),
    .ev_device_err_in(ev[1]), .ev_exec_err_in(ev[2]), .ev_cmd_err_in(ev[3]),
    .ops_idle_in(idle), .err_queue_nonempty_in(eqn), .ques_summary_in(ques),
    .msg_avail_in(mav), .setup_now_in(setup), .setup_load_out(load),
    .setup_data_out(sd), .err_queue_clear_out(eqc), .status_byte_out(sb),
    .srq_out(srq));
  ssr_host_model ssr_host_model_inst (.clk_in(clk), .rst_in(rst),
    .rsp_valid_in(rv), .rsp_field_in(rf), .rsp_data_in(rd),
    .err_add_in(ev[4]), .err_queue_clear_in(eqc),
    .err_queue_nonempty_out(eqn), .id_bytes_out(ids));
  initial forever #12.5 clk = ~clk;
  task summarize;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      summarize;
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    begin
      check_count = check_count + 1;
      if (seen !== e) begin
        failures = failures + 1;
        $display("wrong value %0s exp %h seen %h", nm, e, seen);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // ready moves on rising edges only, so poll it at falling ones
  task cmd(input [3:0] c, input [7:0] a);
    integer n;
    begin
      @(negedge clk);
      vld = 1'b1;
      code = c;
      arg = a;
      for (n = 0; rdy !== 1'b1 && n < 20; n = n + 1)
        @(negedge clk);
      @(negedge clk);
      vld = 1'b0;
    end
  endtask
  task q(input [3:0] c, input [7:0] e);
    begin
      cmd(c, 8'h00);
      chk("answer", {rv, rd}, {1'b1, e});
    end
  endtask
  task pulse(input [4:0] e);
    begin
      ev = e;
      tick(1);
      ev = 5'h00;
      tick(2);
    end
  endtask
  initial begin
    tick(4);
    rst = 1'b0;
    tick(2);
    chk("status", sb, 8'h00);
    q(`SSR_CMD_ESRQ, 8'h80);
    q(`SSR_CMD_ESRQ, 8'h00);
    cmd(`SSR_CMD_ESE, 8'h3d);
    q(`SSR_CMD_ESEQ, 8'h3d);
    pulse(5'h04);
    chk("status", sb, 8'h20);
    cmd(`SSR_CMD_SRE, 8'h20);
    tick(2);
    chk("srq", {srq, sb}, {1'b1, 8'h60});
    q(`SSR_CMD_STBQ, 8'h60);
    cmd(`SSR_CMD_RST, 8'h00);
    q(`SSR_CMD_ESRQ, 8'h10);
    tick(2);
    chk("status", sb, 8'h00);
    cmd(`SSR_CMD_ESE, 8'h00);
    pulse(5'h08);
    cmd(`SSR_CMD_ESE, 8'h3d);
    q(`SSR_CMD_ESRQ, 8'h00);
    pulse(5'h12);
    ques = 1'b1;
    mav = 1'b1;
    tick(2);
    chk("status", sb, 8'h7c);
    cmd(`SSR_CMD_CLS, 8'h00);
    tick(2);
    chk("srq", {srq, sb}, {1'b0, 8'h18});
    q(`SSR_CMD_ESEQ, 8'h3d);
    q(`SSR_CMD_SREQ, 8'h20);
    cmd(`SSR_CMD_SRE, 8'h00);
    q(`SSR_CMD_SREQ, 8'h00);
    mav = 1'b0;
    ques = 1'b0;
    tick(2);
    chk("status", sb, 8'h00);
    idle = 1'b0;
    cmd(`SSR_CMD_OPC, 8'h00);
    tick(3);
    chk("status", sb, 8'h00);
    idle = 1'b1;
    tick(3);
    q(`SSR_CMD_ESRQ, 8'h01);
    pulse(5'h01);
    q(`SSR_CMD_ESRQ, 8'h04);
    setup = 16'h1234;
    cmd(`SSR_CMD_SAV, 8'h09);
    setup = 16'habcd;
    cmd(`SSR_CMD_SAV, 8'h00);
    cmd(`SSR_CMD_RCL, 8'h09);
    chk("load", load, 1'b1);
    tick(2);
    chk("setup", sd, 16'h1234);
    cmd(`SSR_CMD_RCL, 8'h00);
    tick(2);
    chk("setup", sd, 16'habcd);
    cmd(`SSR_CMD_SAV, 8'h0a);
    chk("load", load, 1'b0);
    q(`SSR_CMD_ESRQ, 8'h10);
    cmd(`SSR_CMD_RST, 8'h00);
    tick(2);
    chk("setup", sd, 16'h0000);
    cmd(`SSR_CMD_IDN, 8'h00);
    tick(6);
    chk("ident", ids, 32'h11223344);
    summarize;
  end
endmodule // ssr_status_reporting_bench
